// ===== hdl/csr_setpoint_bank.sv
// charge current and charge voltage setpoint registers behind a serial host port
// assumes pins are synchronous to CLK; SDA is open drain, wire resolved outside
//
// Notes on behaviour
// RULE_01 - current setting is 64 mA per step, 64 mA up to 8.128 A
// RULE_02 - after power-on reset the current setting is zero
// RULE_03 - power-good drop clears current, except when input overvoltage caused it
// RULE_04 - battery-present falling clears current setting to zero
// RULE_05 - overcurrent, thermal, latch-off and system overvoltage leave current alone
// RULE_06 - current field is high bits 4..0 then low bits 7..6
// RULE_07 - any reserved high bit set makes the whole write invalid
// RULE_08 - reserved low-order bits of both low bytes are ignored
// RULE_09 - precharge in linear mode clamps to 384 mA; 2-4 cells hold min system
// RULE_10 - one cell: 3 V precharge threshold, 2 A clamp up to min system
// RULE_11 - voltage in 8 mV steps, writes outside 1.024-19.2 V discarded
// RULE_12 - voltage default follows cell count: 4200/8400/12600/16800 mV
// RULE_13 - with power good, charging starts once current is written
// RULE_14 - host writes voltage before current for non-4.2 V cells
// RULE_15 - writing voltage zero restores default and zeroes current
// RULE_16 - voltage field is high bits 6..0 then low bits 7..3
// RULE_17 - rejected writes leave stored contents and readback unchanged
// RULE_18 - a value changes only after both bytes arrive in one transaction
`timescale 1ns/1ps
module csr_setpoint_bank import csr_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = CSR_I2C_ADDR
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  input wire logic INPUT_POWER_GOOD,
  input wire logic INPUT_OVERVOLTAGE,
  input wire logic BATTERY_PRESENT,
  input wire logic [1:0] CELL_COUNT,
  input wire logic LINEAR_REGULATION_MODE,
  input wire logic [15:0] BATTERY_MV,
  input wire logic [15:0] MIN_SYSTEM_MV,
  output logic [6:0] CHARGE_CURRENT_CODE,
  output logic [11:0] CHARGE_VOLTAGE_CODE,
  output logic CHARGE_ENABLE,
  output logic PRECHARGE_ACTIVE,
  output logic SYSTEM_AT_MIN_REG
);
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] cur_lo;
    logic [7:0] vlt_lo;
    logic cur_ok;
    logic vlt_ok;
    logic [6:0] cur;
    logic [11:0] vlt;
    logic vwr;
    logic pg;
    logic bp;
    logic [11:0] vlt_out;
    logic en;
  } csr_bank_t;

  csr_bank_t q, d;

  logic start_pulse, rx_valid, rx_is_ptr, tx_taken;
  logic [7:0] rx_byte, tx_byte;
  logic data_wr, cur_hi_wr, cur_rsv, cur_commit;
  logic vlt_hi_wr, vlt_zero, vlt_in_rng, vlt_commit;
  logic pg_drop, bat_drop, cur_clear;
  logic [6:0] cur_new;
  logic [11:0] vlt_code, vlt_eff;

  // readback image of a register byte
  function automatic logic [7:0] csr_rd(input logic [7:0] ptr, input logic [6:0] cur,
                                        input logic [11:0] vlt);
    case (ptr)
      CSR_CUR_LO: csr_rd = {cur[1:0], 6'h00};
      CSR_CUR_HI: csr_rd = {3'h0, cur[6:2]};
      CSR_VLT_LO: csr_rd = {vlt[4:0], 3'h0};
      CSR_VLT_HI: csr_rd = {1'b0, vlt[11:5]};
      default: csr_rd = 8'h00;
    endcase
  endfunction : csr_rd

  csr_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_port (
    .clk(CLK),
    .rst_n(RESET_N),
    .scl(SCL),
    .sda_in(SDA_IN),
    .tx_byte(tx_byte),
    .sda_oe(SDA_OE),
    .start_pulse(start_pulse),
    .rx_valid(rx_valid),
    .rx_is_ptr(rx_is_ptr),
    .rx_byte(rx_byte),
    .tx_taken(tx_taken)
  );

  // open drain: only ever pulls low
  assign SDA_OUT = 1'b0;

  assign data_wr = rx_valid & ~rx_is_ptr;

  // current: field of 7 bits, 64 mA per code step
  assign cur_hi_wr = data_wr & (q.ptr == CSR_CUR_HI) & q.cur_ok; // RULE_18
  assign cur_rsv = |rx_byte[7:CSR_CUR_HI_RSV]; // RULE_07
  assign cur_commit = cur_hi_wr & ~cur_rsv; // RULE_07 RULE_17
  assign cur_new = {rx_byte[CSR_CUR_HI_RSV-1:0], q.cur_lo[7:CSR_CUR_LO_POS]}; // RULE_06 RULE_08 RULE_01

  // voltage: field of 12 bits, 8 mV per code step
  assign vlt_code = {rx_byte[CSR_VLT_HI_RSV-1:0], q.vlt_lo[7:CSR_VLT_LO_POS]}; // RULE_16 RULE_08
  assign vlt_hi_wr = data_wr & (q.ptr == CSR_VLT_HI) & q.vlt_ok; // RULE_18
  assign vlt_zero = vlt_hi_wr & ~rx_byte[CSR_VLT_HI_RSV] & (vlt_code == 12'h000); // RULE_15
  assign vlt_in_rng = ~rx_byte[CSR_VLT_HI_RSV] & (vlt_code >= CSR_VLT_MIN) &
    (vlt_code <= CSR_VLT_MAX); // RULE_07 RULE_11
  assign vlt_commit = vlt_hi_wr & vlt_in_rng; // RULE_11 RULE_17

  // hardware clears; overvoltage-caused drop keeps the setting
  assign pg_drop = q.pg & ~INPUT_POWER_GOOD & ~INPUT_OVERVOLTAGE; // RULE_03 RULE_05
  assign bat_drop = q.bp & ~BATTERY_PRESENT; // RULE_04
  assign cur_clear = pg_drop | bat_drop;

  // never-written voltage reads back the cell-count default
  assign vlt_eff = q.vwr ? q.vlt : csr_dflt_vlt(CELL_COUNT); // RULE_12
  assign tx_byte = csr_rd(q.ptr, q.cur, vlt_eff);

  always_comb begin
    d = q;
    d.pg = INPUT_POWER_GOOD;
    d.bp = BATTERY_PRESENT;
    if (start_pulse) begin
      d.cur_ok = 1'b0;
      d.vlt_ok = 1'b0;
    end
    if (rx_valid && rx_is_ptr) begin
      d.ptr = rx_byte;
    end else if (data_wr) begin
      d.ptr = q.ptr + 8'h01;
      case (q.ptr)
        CSR_CUR_LO: begin
          d.cur_lo = rx_byte;
          d.cur_ok = 1'b1;
        end
        CSR_CUR_HI: begin
          d.cur_ok = 1'b0;
          if (cur_commit) begin
            d.cur = cur_new; // RULE_06 RULE_13
          end
        end
        CSR_VLT_LO: begin
          d.vlt_lo = rx_byte;
          d.vlt_ok = 1'b1;
        end
        CSR_VLT_HI: begin
          d.vlt_ok = 1'b0;
          if (vlt_zero) begin
            d.vwr = 1'b0; // RULE_15
            d.cur = CSR_CUR_RST; // RULE_15
          end else if (vlt_commit) begin
            d.vlt = vlt_code; // RULE_16
            d.vwr = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end else if (tx_taken) begin
      d.ptr = q.ptr + 8'h01;
    end
    if (cur_clear) begin
      d.cur = CSR_CUR_RST; // RULE_03 RULE_04
    end
    d.vlt_out = d.vwr ? d.vlt : csr_dflt_vlt(CELL_COUNT); // RULE_12
    d.en = INPUT_POWER_GOOD & (|d.cur); // RULE_13
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      q <= '0;
      q.cur <= CSR_CUR_RST; // RULE_02
    end else begin
      q <= d;
    end
  end

  csr_charge_clamp u_clamp (
    .clk(CLK),
    .rst_n(RESET_N),
    .cur_code(q.cur),
    .cells(CELL_COUNT),
    .linear_en(LINEAR_REGULATION_MODE),
    .batt_mv(BATTERY_MV),
    .min_sys_mv(MIN_SYSTEM_MV),
    .eff_code(CHARGE_CURRENT_CODE),
    .precharge(PRECHARGE_ACTIVE),
    .sys_at_min(SYSTEM_AT_MIN_REG)
  );

  assign CHARGE_VOLTAGE_CODE = q.vlt_out;
  assign CHARGE_ENABLE = q.en;

  cur_reset_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_02
    $rose(RESET_N) |-> q.cur == CSR_CUR_RST && !CHARGE_ENABLE)
    else $error("current not zero after reset");

  pg_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_03
    pg_drop |=> q.cur == 7'h00 && !CHARGE_ENABLE)
    else $error("power-good drop did not clear current");

  ov_keep_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_05
    (q.pg && !INPUT_POWER_GOOD && INPUT_OVERVOLTAGE && !bat_drop && !data_wr)
      |=> $stable(q.cur))
    else $error("overvoltage drop changed current");

  bat_clear_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_04
    bat_drop |=> q.cur == 7'h00)
    else $error("battery removal did not clear current");

  cur_field_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_06
    (cur_commit && !cur_clear) |=>
      q.cur == {$past(rx_byte[4:0]), $past(q.cur_lo[7:6])})
    else $error("current field not stored as written");

  cur_rsv_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_07
    (data_wr && q.ptr == CSR_CUR_HI && cur_rsv && !cur_clear) |=> $stable(q.cur))
    else $error("reserved-bit current write was accepted");

  half_write_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_18
    (data_wr && q.ptr == CSR_CUR_LO && !cur_clear) |=> $stable(q.cur))
    else $error("low byte alone changed current");

  vlt_range_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_11
    q.vwr |-> q.vlt >= CSR_VLT_MIN && q.vlt <= CSR_VLT_MAX)
    else $error("stored voltage outside range");

  vlt_zero_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_15
    vlt_zero |=> !q.vwr && q.cur == 7'h00 ##1
      CHARGE_VOLTAGE_CODE == csr_dflt_vlt($past(CELL_COUNT)))
    else $error("zero voltage write did not restore default");

  vlt_dflt_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_12
    (!q.vwr && !vlt_commit) |=> CHARGE_VOLTAGE_CODE == csr_dflt_vlt($past(CELL_COUNT)))
    else $error("voltage default does not follow cell count");

  enable_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_13
    (INPUT_POWER_GOOD && cur_commit && cur_new != 7'h00 && !cur_clear) |=> CHARGE_ENABLE)
    else $error("charge did not start on current write");

  // stored state, staging and readback image
  rst_out_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_02
    $rose(RESET_N) |-> CHARGE_VOLTAGE_CODE == 12'h000 && !SDA_OE &&
      CHARGE_CURRENT_CODE == 7'h00)
    else $error("outputs not cleared by reset");

  stage_clr_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_18
    start_pulse
      |=> !q.cur_ok && !q.vlt_ok)
    else $error("staged low byte survived a start");

  cur_lone_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_18
    (data_wr && q.ptr == CSR_CUR_HI && !q.cur_ok && !cur_clear)
      |=> $stable(q.cur))
    else $error("high byte alone changed current");

  cur_keep_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_05
    (!data_wr && !cur_clear)
      |=> $stable(q.cur))
    else $error("current changed without write or clear");

  rd_rsv_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_07
    (q.ptr == CSR_CUR_HI || q.ptr == CSR_VLT_HI)
      |-> !tx_byte[7])
    else $error("reserved readback bit set");

  rd_low_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_08
    (q.ptr == CSR_CUR_LO)
      |-> tx_byte[5:0] == 6'h00 && tx_byte[7:6] == q.cur[1:0])
    else $error("current low byte readback wrong");

  vlt_store_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_16
    vlt_commit |=> q.vwr &&
      q.vlt == {$past(rx_byte[6:0]), $past(q.vlt_lo[7:3])})
    else $error("voltage field not stored as written");

  vlt_rsv_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_07
    (vlt_hi_wr && rx_byte[CSR_VLT_HI_RSV])
      |=> $stable(q.vlt) && $stable(q.vwr))
    else $error("reserved-bit voltage write was accepted");

  vlt_reject_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_11
    (vlt_hi_wr && !vlt_in_rng && vlt_code != 12'h000)
      |=> $stable(q.vlt) && $stable(q.vwr))
    else $error("out-of-range voltage write was accepted");

  vlt_keep_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_17
    !data_wr
      |=> $stable(q.vlt) && $stable(q.vwr))
    else $error("voltage changed without a write");

  vlt_out_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_13
    (q.vwr && !vlt_hi_wr)
      |=> CHARGE_VOLTAGE_CODE == $past(q.vlt))
    else $error("written voltage not applied");

  en_level_a: assert property (@(posedge CLK) disable iff (!RESET_N) // RULE_13
    CHARGE_ENABLE
      == ($past(INPUT_POWER_GOOD) && q.cur != 7'h00))
    else $error("charge enable does not follow current");
endmodule : csr_setpoint_bank

// ===== hdl/csr_pkg.sv
// charge setpoint register bank: shared offsets, field layout, limits and states
// assumes 8-bit register pointer and byte-wide serial host access
package csr_pkg;
  localparam logic [7:0] CSR_CUR_LO = 8'h02;
  localparam logic [7:0] CSR_CUR_HI = 8'h03;
  localparam logic [7:0] CSR_VLT_LO = 8'h04;
  localparam logic [7:0] CSR_VLT_HI = 8'h05;
  localparam int CSR_CUR_W = 7;
  localparam int CSR_VLT_W = 12;
  // lowest reserved bit of each high byte, field lsb in low bytes
  localparam int CSR_CUR_HI_RSV = 5;
  localparam int CSR_CUR_LO_POS = 6;
  localparam int CSR_VLT_HI_RSV = 7;
  localparam int CSR_VLT_LO_POS = 3;
  localparam logic [6:0] CSR_CUR_RST = 7'h00;
  localparam int CSR_CUR_STEP_MA = 64;
  localparam int CSR_VLT_STEP_MV = 8;
  localparam int CSR_VLT_MIN_MV = 1024;
  localparam int CSR_VLT_MAX_MV = 19200;
  localparam logic [11:0] CSR_VLT_MIN = 12'(CSR_VLT_MIN_MV / CSR_VLT_STEP_MV);
  localparam logic [11:0] CSR_VLT_MAX = 12'(CSR_VLT_MAX_MV / CSR_VLT_STEP_MV);
  localparam int CSR_DFLT_1S_MV = 4200;
  localparam int CSR_DFLT_2S_MV = 8400;
  localparam int CSR_DFLT_3S_MV = 12600;
  localparam int CSR_DFLT_4S_MV = 16800;
  localparam int CSR_PRE_CLAMP_MA = 384;
  localparam int CSR_FAST_CLAMP_MA = 2000;
  localparam logic [6:0] CSR_PRE_CLAMP = 7'(CSR_PRE_CLAMP_MA / CSR_CUR_STEP_MA);
  localparam logic [6:0] CSR_FAST_CLAMP = 7'(CSR_FAST_CLAMP_MA / CSR_CUR_STEP_MA);
  localparam int CSR_PRE_1S_THR_MV = 3000;
  localparam logic [15:0] CSR_PRE_1S_THR = 16'(CSR_PRE_1S_THR_MV);
  localparam logic [1:0] CSR_ONE_CELL = 2'h0;
  localparam logic [6:0] CSR_I2C_ADDR = 7'h6B;

  typedef enum logic [6:0] {
    CSR_S_IDLE = 7'h01, CSR_S_ADDR = 7'h02, CSR_S_AACK = 7'h04, CSR_S_RX = 7'h08,
    CSR_S_DACK = 7'h10, CSR_S_TX = 7'h20, CSR_S_MACK = 7'h40
  } csr_i2c_st_t;

  // cell-count pin code 0..3 means one to four cells
  function automatic logic [11:0] csr_dflt_vlt(input logic [1:0] cells);
    case (cells)
      2'h0: csr_dflt_vlt = 12'(CSR_DFLT_1S_MV / CSR_VLT_STEP_MV);
      2'h1: csr_dflt_vlt = 12'(CSR_DFLT_2S_MV / CSR_VLT_STEP_MV);
      2'h2: csr_dflt_vlt = 12'(CSR_DFLT_3S_MV / CSR_VLT_STEP_MV);
      default: csr_dflt_vlt = 12'(CSR_DFLT_4S_MV / CSR_VLT_STEP_MV);
    endcase
  endfunction : csr_dflt_vlt
endpackage : csr_pkg

// ===== hdl/csr_i2c_slave.sv
// byte-level serial slave: start/stop, address match, ack, shift in/out
// assumes scl/sda already synchronous to clk and far slower than it
`timescale 1ns/1ps
module csr_i2c_slave import csr_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = CSR_I2C_ADDR
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic [7:0] tx_byte,
  output logic sda_oe,
  output logic start_pulse,
  output logic rx_valid,
  output logic rx_is_ptr,
  output logic [7:0] rx_byte,
  output logic tx_taken
);
  typedef struct packed {
    csr_i2c_st_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw, ack, first, scl, sda, oe, start, rxv, rxp, taken;
  } csr_i2c_t;

  csr_i2c_t q, d;
  logic rise, fall;

  // load a byte to send; bit 7 goes out first
  function automatic csr_i2c_t csr_load(input csr_i2c_t s, input logic [7:0] b);
    csr_i2c_t r;
    r = s;
    r.sh = b;
    r.oe = ~b[7];
    r.cnt = 4'h1;
    r.taken = 1'b1;
    r.st = CSR_S_TX;
    return r;
  endfunction : csr_load

  assign rise = scl & ~q.scl;
  assign fall = ~scl & q.scl;

  always_comb begin
    d = q;
    d.start = 1'b0;
    d.rxv = 1'b0;
    d.taken = 1'b0;
    d.scl = scl;
    d.sda = sda_in;
    if (q.scl && scl && q.sda && !sda_in) begin
      d.st = CSR_S_ADDR;
      d.cnt = 4'h0;
      d.first = 1'b1;
      d.oe = 1'b0;
      d.start = 1'b1;
    end else if (q.scl && scl && !q.sda && sda_in) begin
      d.st = CSR_S_IDLE;
      d.oe = 1'b0;
    end else begin
      case (q.st)
        CSR_S_ADDR, CSR_S_RX: begin
          if (rise) begin
            d.sh = {q.sh[6:0], sda_in};
            d.cnt = q.cnt + 4'h1;
          end else if (fall && q.cnt == 4'h8) begin
            if (q.st == CSR_S_RX) begin
              d.rxv = 1'b1;
              d.rxp = q.first;
              d.first = 1'b0;
              d.oe = 1'b1;
              d.st = CSR_S_DACK;
            end else if (q.sh[7:1] == DEV_ADDR) begin
              d.rw = q.sh[0];
              d.oe = 1'b1;
              d.st = CSR_S_AACK;
            end else begin
              d.st = CSR_S_IDLE;
            end
          end
        end
        CSR_S_AACK: begin
          if (fall && q.rw) begin
            d = csr_load(d, tx_byte);
          end else if (fall) begin
            d.oe = 1'b0;
            d.cnt = 4'h0;
            d.st = CSR_S_RX;
          end
        end
        CSR_S_DACK: begin
          if (fall) begin
            d.oe = 1'b0;
            d.cnt = 4'h0;
            d.st = CSR_S_RX;
          end
        end
        CSR_S_TX: begin
          if (fall && q.cnt == 4'h8) begin
            d.oe = 1'b0;
            d.st = CSR_S_MACK;
          end else if (fall) begin
            d.sh = {q.sh[6:0], 1'b0};
            d.oe = ~q.sh[6];
            d.cnt = q.cnt + 4'h1;
          end
        end
        CSR_S_MACK: begin
          if (rise) begin
            d.ack = ~sda_in;
          end else if (fall && q.ack) begin
            d = csr_load(d, tx_byte);
          end else if (fall) begin
            d.st = CSR_S_IDLE;
          end
        end
        CSR_S_IDLE: begin
        end
        default: d.st = CSR_S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
      q.st <= CSR_S_IDLE;
      q.scl <= 1'b1;
      q.sda <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign sda_oe = q.oe;
  assign start_pulse = q.start;
  assign rx_valid = q.rxv;
  assign rx_is_ptr = q.rxp;
  assign rx_byte = q.sh;
  assign tx_taken = q.taken;
endmodule : csr_i2c_slave

// ===== hdl/csr_charge_clamp.sv
// precharge and low-battery fast-charge current clamps on the current code
// assumes battery and minimum system voltage arrive as settled mV words
`timescale 1ns/1ps
module csr_charge_clamp import csr_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [6:0] cur_code,
  input wire logic [1:0] cells,
  input wire logic linear_en,
  input wire logic [15:0] batt_mv,
  input wire logic [15:0] min_sys_mv,
  output logic [6:0] eff_code,
  output logic precharge,
  output logic sys_at_min
);
  typedef struct packed {
    logic [6:0] eff;
    logic pre;
    logic at_min;
  } csr_clamp_t;

  csr_clamp_t q, d;
  logic one_cell, pre_now, fast_win;

  assign one_cell = cells == CSR_ONE_CELL;
  assign pre_now = linear_en &
    (one_cell ? batt_mv < CSR_PRE_1S_THR : batt_mv < min_sys_mv); // RULE_09 RULE_10
  assign fast_win = linear_en & one_cell & batt_mv >= CSR_PRE_1S_THR &
    batt_mv < min_sys_mv; // RULE_10

  always_comb begin
    d.eff = cur_code;
    if (pre_now && cur_code > CSR_PRE_CLAMP) begin
      d.eff = CSR_PRE_CLAMP; // RULE_09
    end else if (fast_win && cur_code > CSR_FAST_CLAMP) begin
      d.eff = CSR_FAST_CLAMP; // RULE_10
    end
    d.pre = pre_now;
    d.at_min = pre_now & ~one_cell; // RULE_09
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign eff_code = q.eff;
  assign precharge = q.pre;
  assign sys_at_min = q.at_min;

  pre_clamp_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
    pre_now |=> eff_code <= CSR_PRE_CLAMP && precharge)
    else $error("precharge current above clamp");
  fast_clamp_a: assert property (@(posedge clk) disable iff (!rst_n) // RULE_10
    (fast_win && !pre_now) |=> eff_code <= CSR_FAST_CLAMP &&
      (eff_code == $past(cur_code) || $past(cur_code) > CSR_FAST_CLAMP))
    else $error("single-cell fast charge clamp wrong");
endmodule : csr_charge_clamp

// ===== verification/csr_host_model.sv
// serial host model: start, stop and byte transfers on an open-drain bus
// assumes the bench resolves the data wire with a pull-up and feeds it back
`timescale 1ns/1ps
module csr_host_model (
  input wire logic clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda_o
);
  localparam int Q = 3;

  // bus idle: both lines released high
  initial begin
    scl = 1'h1;
    sda_o = 1'h1;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic bit_out(input logic b);
    sda_o = b;
    tick(Q);
    scl = 1'h1;
    tick(2 * Q);
    scl = 1'h0;
    tick(Q);
  endtask : bit_out

  task automatic bit_in(output logic b);
    sda_o = 1'h1;
    tick(Q);
    scl = 1'h1;
    tick(Q);
    b = sda_w;
    tick(Q);
    scl = 1'h0;
    tick(Q);
  endtask : bit_in

  task automatic start();
    sda_o = 1'h1;
    tick(Q);
    scl = 1'h1;
    tick(Q);
    sda_o = 1'h0;
    tick(Q);
    scl = 1'h0;
    tick(Q);
  endtask : start

  task automatic stop();
    sda_o = 1'h0;
    tick(Q);
    scl = 1'h1;
    tick(Q);
    sda_o = 1'h1;
    tick(Q);
  endtask : stop

  task automatic put(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_out(d[i]);
    bit_in(a);
    ack = ~a;
  endtask : put

  // last byte of a read is answered with a release (no ack)
  task automatic get(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_in(d[i]);
    bit_out(last);
  endtask : get
endmodule : csr_host_model

// ===== verification/test_charge_setpoint_registers.sv
// self-checking bench for the charge setpoint register bank
// assumes the host model owns the serial bus; data wire has a pull-up
`timescale 1ns/1ps
module test_charge_setpoint_registers import csr_pkg::*;;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic pg = 1'h1;
  logic ov = 1'h0;
  logic bp = 1'h1;
  logic lin = 1'h0;
  logic [1:0] cells = 2'h0;
  logic [15:0] bmv = 16'h4E20;
  logic [15:0] smv = 16'h0E00;
  logic scl, sda_o, sda_out, sda_oe, sda_w, ack;
  logic [6:0] cur_o, c;
  logic [11:0] vlt_o, v, w;
  logic en_o, pre_o, min_o;
  logic probe_v = 1'h0;
  logic [15:0] probe_d;
  logic [15:0] exp_q[$];
  int errors = 0;
  int tests_run = 0;

  always #2.5 clk = ~clk;
  assign sda_w = sda_o & (sda_oe ? sda_out : 1'h1);

  csr_setpoint_bank dut_u (.CLK(clk), .RESET_N(reset_n), .SCL(scl), .SDA_IN(sda_w),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .INPUT_POWER_GOOD(pg), .INPUT_OVERVOLTAGE(ov),
    .BATTERY_PRESENT(bp), .CELL_COUNT(cells), .LINEAR_REGULATION_MODE(lin),
    .BATTERY_MV(bmv), .MIN_SYSTEM_MV(smv), .CHARGE_CURRENT_CODE(cur_o),
    .CHARGE_VOLTAGE_CODE(vlt_o), .CHARGE_ENABLE(en_o), .PRECHARGE_ACTIVE(pre_o),
    .SYSTEM_AT_MIN_REG(min_o));
  csr_host_model host_u (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_o(sda_o));

  task automatic wrap_up();
    if (errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  // oldest note against each probed result
  always @(posedge clk) begin
    if (probe_v) begin
      tests_run++;
      if (probe_d !== exp_q[0]) begin
        errors++;
        $display("BAD t=%0t exp=%h got=%h", $time, exp_q[0], probe_d);
      end
      void'(exp_q.pop_front());
    end
  end

  initial begin
    repeat (80000) @(posedge clk);
    errors++;
    wrap_up();
  end

  function automatic logic [15:0] cur_rb(input logic [6:0] k);
    return {3'h0, k, 6'h00};
  endfunction : cur_rb

  function automatic logic [15:0] vlt_rb(input logic [11:0] k);
    return {1'h0, k, 3'h0};
  endfunction : vlt_rb

  function automatic logic [15:0] dflt(input logic [1:0] n);
    return 16'((CSR_DFLT_1S_MV / CSR_VLT_STEP_MV) * (int'(n) + 1));
  endfunction : dflt

  task automatic check(input logic [15:0] e, input logic [15:0] g);
    exp_q.push_back(e);
    probe_d = g;
    probe_v = 1'h1;
    @(negedge clk);
    probe_v = 1'h0;
    @(negedge clk);
  endtask : check

  task automatic settle();
    repeat (4) @(negedge clk);
  endtask : settle

  task automatic do_reset();
    reset_n = 1'h0;
    repeat (8) @(negedge clk);
    reset_n = 1'h1;
    repeat (2) @(negedge clk);
  endtask : do_reset

  // one data byte, or two when n > 1, with auto-increment from pointer p
  task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n);
    host_u.start();
    host_u.put({CSR_I2C_ADDR, 1'h0}, ack);
    host_u.put(p, ack);
    host_u.put(d[7:0], ack);
    if (n > 1) host_u.put(d[15:8], ack);
    host_u.stop();
    check(16'h0001, {15'h0000, ack});
  endtask : wr

  task automatic chk_rd(input logic [7:0] p, input logic [15:0] e);
    logic [15:0] g;
    host_u.start();
    host_u.put({CSR_I2C_ADDR, 1'h0}, ack);
    host_u.put(p, ack);
    host_u.start();
    host_u.put({CSR_I2C_ADDR, 1'h1}, ack);
    host_u.get(1'h0, g[7:0]);
    host_u.get(1'h1, g[15:8]);
    host_u.stop();
    check(e, g);
  endtask : chk_rd

  initial begin
    void'($urandom(80367));
    for (int n = 0; n < 4; n++) begin
      cells = 2'(n);
      do_reset();
      check(dflt(cells), {4'h0, vlt_o});
      chk_rd(CSR_VLT_LO, vlt_rb(12'(dflt(cells))));
      chk_rd(CSR_CUR_LO, 16'h0000);
    end
    for (int i = 0; i < 3; i++) begin
      c = (i == 0) ? 7'h01 : (i == 1) ? 7'h7F : 7'($urandom_range(126, 2));
      wr(CSR_CUR_LO, cur_rb(c) | 16'($urandom_range(63, 0)), 2);
      chk_rd(CSR_CUR_LO, cur_rb(c));
      check({9'h000, c}, {9'h000, cur_o});
      check(16'h0001, {15'h0000, en_o});
    end
    // reserved high bits spoil the whole write
    for (int k = 5; k < 8; k++) wr(CSR_CUR_LO, cur_rb(~c) | (16'h0001 << (8 + k)), 2);
    chk_rd(CSR_CUR_LO, cur_rb(c));
    // half writes and split transactions
    wr(CSR_CUR_HI, cur_rb(~c) >> 8, 1);
    wr(CSR_CUR_LO, cur_rb(~c), 1);
    wr(CSR_CUR_HI, cur_rb(~c) >> 8, 1);
    chk_rd(CSR_CUR_LO, cur_rb(c));
    wr(8'h10, 16'hFFFF, 2);
    chk_rd(8'h10, 16'h0000);
    v = 12'($urandom_range(2399, 129));
    wr(CSR_VLT_LO, vlt_rb(v) | 16'($urandom_range(7, 0)), 2);
    chk_rd(CSR_VLT_LO, vlt_rb(v));
    check({4'h0, v}, {4'h0, vlt_o});
    for (int i = 0; i < 4; i++) begin
      v = (i < 2) ? 12'h080 : 12'h960;
      w = (i == 1) ? v - 12'h001 : (i == 3) ? v + 12'h001 : v;
      wr(CSR_VLT_LO, vlt_rb(w), 2);
      chk_rd(CSR_VLT_LO, vlt_rb(v));
    end
    wr(CSR_VLT_LO, vlt_rb(12'h100) | 16'h8000, 2);
    chk_rd(CSR_VLT_LO, vlt_rb(v));
    wr(CSR_VLT_LO, 16'($urandom_range(7, 0)), 2);
    chk_rd(CSR_VLT_LO, vlt_rb(12'(dflt(cells))));
    chk_rd(CSR_CUR_LO, 16'h0000);
    check(16'h0000, {15'h0000, en_o});
    // power and battery events
    wr(CSR_CUR_LO, cur_rb(c), 2);
    ov = 1'h1;
    pg = 1'h0;
    settle();
    chk_rd(CSR_CUR_LO, cur_rb(c));
    pg = 1'h1;
    ov = 1'h0;
    settle();
    pg = 1'h0;
    settle();
    check(16'h0000, {9'h000, cur_o});
    pg = 1'h1;
    settle();
    check(16'h0000, {15'h0000, en_o});
    wr(CSR_CUR_LO, cur_rb(c), 2);
    bp = 1'h0;
    settle();
    check(16'h0000, {9'h000, cur_o});
    bp = 1'h1;
    // current clamps
    wr(CSR_CUR_LO, cur_rb(7'h40), 2);
    cells = 2'h1;
    lin = 1'h1;
    smv = 16'h1800;
    bmv = 16'h1388;
    settle();
    check(16'(CSR_PRE_CLAMP_MA / CSR_CUR_STEP_MA), {9'h000, cur_o});
    check(16'h0003, {14'h0000, pre_o, min_o});
    cells = 2'h0;
    smv = 16'h0E00;
    bmv = 16'h09C4;
    settle();
    check(16'h0002, {14'h0000, pre_o, min_o});
    check(16'(CSR_PRE_CLAMP_MA / CSR_CUR_STEP_MA), {9'h000, cur_o});
    bmv = 16'h0CE4;
    settle();
    check(16'(CSR_FAST_CLAMP_MA / CSR_CUR_STEP_MA), {9'h000, cur_o});
    bmv = 16'h4E20;
    settle();
    check(16'h0040, {7'h00, pre_o, 1'h0, cur_o});
    wrap_up();
  end
endmodule : test_charge_setpoint_registers
